// file: hw/clocked_serial_shift_port.sv
// clocked serial shift port with apb register access
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module clocked_serial_shift_port
   import serial_shift_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // register bus
   input wire apb_req_s apb_req_i,
   output apb_rsp_s apb_rsp_o,
   // transfer clock pin
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   // data pins
   input wire logic si_i,
   output logic so_o,
   output logic so_oe_o
);

   serial_state_e state_q;
   apb_rsp_s rsp_q;
   logic [3:0] serial_mode_reg_q;
   logic [1:0] port_mode_a_q;
   logic [1:0] port_mode_c_q;
   logic [7:0] shift_register_q;
   logic [2:0] bit_counter_q;
   logic transfer_done_flag_q;
   logic so_q;
   logic so_oe_q;
   logic sck_oe_q;
   logic sck_gen_q;
   logic [DIV_CNT_W-1:0] div_cnt_q;
   logic sck_s1_q;
   logic sck_s2_q;
   logic sck_s3_q;
   logic si_s1_q;
   logic si_s2_q;

   logic bus_write;
   logic bus_setup;
   logic wr_mode;
   logic wr_portc;
   logic wr_shift;
   logic start_cmd;
   logic clear_done;
   logic internal_clk;
   logic [1:0] op_mode;
   logic tx_active;
   logic gen_run;
   logic gen_tick;
   logic [DIV_CNT_W-1:0] half_m1;
   logic fall_ev;
   logic rise_ev;
   logic done_ev;
   logic mapped;
   logic [31:0] rd_data;

   // ---------------- register bus ----------------
   assign bus_setup = apb_req_i.psel & ~apb_req_i.penable;
   // a write lands at the access edge where pready is sampled high
   assign bus_write = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & rsp_q.pready;
   assign wr_mode = bus_write & (apb_req_i.paddr == ADDR_SERIAL_MODE);
   assign wr_portc = bus_write & (apb_req_i.paddr == ADDR_PORT_MODE_C);
   assign wr_shift = bus_write & (apb_req_i.paddr == ADDR_SHIFT);
   assign start_cmd = bus_write & (apb_req_i.paddr == ADDR_COMMAND)
      & apb_req_i.pwdata[CMD_START_BIT];
   assign clear_done = bus_write & (apb_req_i.paddr == ADDR_STATUS)
      & apb_req_i.pwdata[STATUS_DONE_BIT];

   always_comb begin
      mapped = 1'b1;
      rd_data = 32'h0000_0000;
      case (apb_req_i.paddr)
         ADDR_SERIAL_MODE: rd_data[3:0] = serial_mode_reg_q;
         ADDR_PORT_MODE_A: rd_data[1:0] = port_mode_a_q;
         ADDR_PORT_MODE_C: rd_data[1:0] = port_mode_c_q;
         ADDR_SHIFT: rd_data[7:0] = shift_register_q;
         ADDR_COMMAND: rd_data = 32'h0000_0000;
         ADDR_STATUS: begin
            rd_data[STATUS_DONE_BIT] = transfer_done_flag_q;
            rd_data[STATUS_STATE_LSB +: 2] = state_q;
            rd_data[STATUS_COUNT_LSB +: 3] = bit_counter_q;
         end
         default: mapped = 1'b0;
      endcase
   end

   // zero wait states: answer is ready in the first access cycle
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rsp_q <= '0;
      end else if (bus_setup) begin
         rsp_q.pready <= 1'b1;
         rsp_q.pslverr <= ~mapped;
         rsp_q.prdata <= apb_req_i.pwrite ? 32'h0000_0000 : rd_data;
      end else begin
         rsp_q <= '0;
      end
   end

   assign apb_rsp_o = rsp_q;

   // ---------------- configuration registers ----------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         serial_mode_reg_q <= SERIAL_MODE_RESET;
         port_mode_a_q <= PORT_MODE_A_RESET;
         port_mode_c_q <= PORT_MODE_C_RESET;
      end else if (bus_write) begin
         if (apb_req_i.paddr == ADDR_SERIAL_MODE) begin
            serial_mode_reg_q <= apb_req_i.pwdata[3:0];
         end
         if (apb_req_i.paddr == ADDR_PORT_MODE_A) begin
            port_mode_a_q <= apb_req_i.pwdata[1:0];
         end
         if (apb_req_i.paddr == ADDR_PORT_MODE_C) begin
            port_mode_c_q <= apb_req_i.pwdata[1:0];
         end
      end
   end

   assign op_mode = {port_mode_a_q[PORTA_IN_FN_BIT], port_mode_a_q[PORTA_OUT_FN_BIT]};
   assign tx_active = op_mode[0];
   assign internal_clk = serial_mode_reg_q[2:0] != CLKSEL_EXTERNAL;

   // ---------------- pin synchronisers ----------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sck_s1_q <= 1'b1;
         sck_s2_q <= 1'b1;
         sck_s3_q <= 1'b1;
         si_s1_q <= 1'b0;
         si_s2_q <= 1'b0;
      end else begin
         sck_s1_q <= sck_i;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         si_s1_q <= si_i;
         si_s2_q <= si_s1_q;
      end
   end

   // ---------------- internal transfer clock ----------------
   // half period is a power of two; system clock choice is the fastest
   // rate a registered pin can carry, one cycle high and one low
   always_comb begin
      if (serial_mode_reg_q[2:0] == CLKSEL_SYSTEM) begin
         half_m1 = '0;
      end else begin
         half_m1 = DIV_CNT_W'((DIV_CNT_W'(1) << (HALF_LOG_BASE
            - 2 * int'(serial_mode_reg_q[2:0])
            + int'(port_mode_c_q[PORTC_DIV_BIT]))) - DIV_CNT_W'(1));
      end
   end

   // generator stops outside clock-wait, transfer and continuous states
   assign gen_run = internal_clk & (state_q != ST_INSTR_WAIT);
   assign gen_tick = gen_run & (div_cnt_q == half_m1);

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         div_cnt_q <= '0;
         sck_gen_q <= 1'b1;
      end else if (!gen_run || wr_mode) begin
         div_cnt_q <= '0;
         sck_gen_q <= 1'b1;
      end else if (gen_tick) begin
         div_cnt_q <= '0;
         sck_gen_q <= ~sck_gen_q;
      end else begin
         div_cnt_q <= div_cnt_q + DIV_CNT_W'(1);
      end
   end

   // edges of whichever transfer clock is selected
   always_comb begin
      if (internal_clk) begin
         fall_ev = gen_tick & sck_gen_q;
         rise_ev = gen_tick & ~sck_gen_q;
      end else begin
         fall_ev = sck_s3_q & ~sck_s2_q;
         rise_ev = ~sck_s3_q & sck_s2_q;
      end
   end

   // pin is the generator flop itself: a second register here would let so_o
   // move one cycle ahead of the falling clock edge on the pin
   assign sck_o = sck_gen_q;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sck_oe_o <= 1'b0;
      end else begin
         sck_oe_o <= serial_mode_reg_q[MODE_PIN_FN_BIT] & internal_clk;
      end
   end

   // ---------------- state machine ----------------
   assign done_ev = (state_q == ST_TRANSFER) & rise_ev & (bit_counter_q == COUNT_LAST);

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_q <= ST_INSTR_WAIT;
      end else if (wr_mode) begin
         state_q <= ST_INSTR_WAIT;
      end else begin
         case (state_q)
            ST_INSTR_WAIT: begin
               // transfer clock edges are ignored here
               if (start_cmd) begin
                  state_q <= ST_CLOCK_WAIT;
               end
            end
            ST_CLOCK_WAIT: begin
               if (fall_ev) begin
                  if (internal_clk && op_mode == OPMODE_CONT_CLK) begin
                     state_q <= ST_CONT_CLOCK;
                  end else begin
                     state_q <= ST_TRANSFER;
                  end
               end
            end
            ST_TRANSFER: begin
               if (start_cmd) begin
                  state_q <= ST_CLOCK_WAIT;
               end else if (done_ev) begin
                  state_q <= internal_clk ? ST_INSTR_WAIT : ST_CLOCK_WAIT;
               end
            end
            ST_CONT_CLOCK: begin
               state_q <= ST_CONT_CLOCK;
            end
            default: state_q <= ST_INSTR_WAIT;
         endcase
      end
   end

   // bit counter counts rising edges of the transfer
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         bit_counter_q <= COUNT_RESET;
      end else if (wr_mode || start_cmd || done_ev) begin
         bit_counter_q <= COUNT_RESET;
      end else if (state_q == ST_TRANSFER && rise_ev) begin
         bit_counter_q <= bit_counter_q + 3'h1;
      end
   end

   // done flag: a hardware set beats a software clear in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         transfer_done_flag_q <= 1'b0;
      end else if (state_q == ST_TRANSFER && (wr_mode || start_cmd || done_ev)) begin
         transfer_done_flag_q <= 1'b1;
      end else if (clear_done) begin
         transfer_done_flag_q <= 1'b0;
      end
   end

   // ---------------- data path ----------------
   // shift on rising edges, so the eighth rise completes the character
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         shift_register_q <= SHIFT_RESET;
      end else if (state_q == ST_TRANSFER && rise_ev) begin
         shift_register_q <= {si_s2_q, shift_register_q[7:1]};
      end else if (wr_shift) begin
         shift_register_q <= apb_req_i.pwdata[7:0];
      end
   end

   // output bit changes at falling edges and on idle-level writes, then holds the last (MSB) bit
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         so_q <= 1'b0;
      end else if (wr_portc) begin
         so_q <= apb_req_i.pwdata[PORTC_IDLE_BIT];
      end else if (tx_active && fall_ev && (state_q == ST_TRANSFER
            || (state_q == ST_CLOCK_WAIT && !wr_mode))) begin
         so_q <= shift_register_q[0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         so_oe_q <= 1'b0;
      end else begin
         so_oe_q <= port_mode_a_q[PORTA_OUT_FN_BIT];
      end
   end

   assign so_o = so_q;
   assign so_oe_o = so_oe_q;

endmodule // clocked_serial_shift_port

// file: hw/serial_shift_pkg.sv
// constants, types and field layout of the clocked serial shift port
// What this block does
// - one eight-bit character, LSB first
// - drive on falling edge, sample on rising
// - external or thirteen internal clock choices
// - internal clock driven out on clock pin
// - start clears counter; rising edges increment it
// - eight cycles or abort: counter cleared, done set
// - reset gives instruction-wait; clocks ignored there
// - first falling edge in clock-wait starts transfer
// - mode 00 internal: endless clock, no data
// - mode register write aborts, returns to instruction-wait
// - start during transfer clears counter, enters clock-wait
// - leaving transfer clears counter, sets done
// - after eight: external clock-wait, internal instruction-wait
// - internal clock stops after eight cycles
// - external clock in clock-wait repeats transfer
// - idle-level write drives output pin at once
// - output holds transmitted MSB until idle write
// - any mode register write reinitialises state
// - shift right, LSB out, new data at top
// - pin function plus two mode bits pick mode; code ignores pin function here, which only enables the clock pin
package serial_shift_pkg;

   // apb byte addresses
   localparam logic [7:0] ADDR_SERIAL_MODE = 8'h00;
   localparam logic [7:0] ADDR_PORT_MODE_A = 8'h04;
   localparam logic [7:0] ADDR_PORT_MODE_C = 8'h08;
   localparam logic [7:0] ADDR_SHIFT = 8'h0C;
   localparam logic [7:0] ADDR_COMMAND = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // field positions
   localparam int MODE_PIN_FN_BIT = 3;
   localparam int PORTA_IN_FN_BIT = 1;
   localparam int PORTA_OUT_FN_BIT = 0;
   localparam int PORTC_IDLE_BIT = 1;
   localparam int PORTC_DIV_BIT = 0;
   localparam int CMD_START_BIT = 0;
   localparam int STATUS_DONE_BIT = 0;
   localparam int STATUS_STATE_LSB = 2;
   localparam int STATUS_COUNT_LSB = 4;

   // reset values
   localparam logic [3:0] SERIAL_MODE_RESET = 4'h0;
   localparam logic [1:0] PORT_MODE_A_RESET = 2'h0;
   localparam logic [1:0] PORT_MODE_C_RESET = 2'h0;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [2:0] COUNT_RESET = 3'h0;

   // clock select codes and divider shape
   localparam logic [2:0] CLKSEL_SYSTEM = 3'h6;
   localparam logic [2:0] CLKSEL_EXTERNAL = 3'h7;
   localparam int HALF_LOG_BASE = 11;
   localparam int DIV_CNT_W = 13;
   localparam logic [2:0] COUNT_LAST = 3'h7;

   // operating modes from the two port mode bits
   localparam logic [1:0] OPMODE_CONT_CLK = 2'h0;
   localparam logic [1:0] OPMODE_TX = 2'h1;
   localparam logic [1:0] OPMODE_RX = 2'h2;
   localparam logic [1:0] OPMODE_TXRX = 2'h3;

   typedef enum logic [1:0] {
      ST_INSTR_WAIT = 2'b00,
      ST_CLOCK_WAIT = 2'b01,
      ST_TRANSFER = 2'b10,
      ST_CONT_CLOCK = 2'b11
   } serial_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;

endpackage

// file: verif/serial_peer_model.sv
// external serial peer: makes or follows the clock, swaps one byte
`timescale 1ns/1ps
module serial_peer_model (
   // pacing clock
   input wire logic clk_sys_i,
   // device pins
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic so_o,
   // peer pins
   output logic sck_i,
   output logic si_i
);
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   int nrise;
   logic sck_w;
   assign sck_w = sck_oe_o ? sck_o : sck_i;
   initial begin
      sck_i = 1'b1;
      si_i = 1'b0;
      tx_q = 8'h00;
      rx_q = 8'h00;
      nrise = 0;
   end
   always @(negedge sck_w) begin
      si_i <= tx_q[0];
      tx_q <= {tx_q[0], tx_q[7:1]};
   end
   always @(posedge sck_w) begin
      rx_q <= {so_o, rx_q[7:1]};
      nrise <= nrise + 1;
   end
   // clock idles high between frames; data line flips so stale bits never match
   task automatic clocks(input int n, input int half);
      repeat (n) begin
         @(posedge clk_sys_i) sck_i <= 1'b0;
         repeat (half) @(posedge clk_sys_i);
         sck_i <= 1'b1;
         repeat (half) @(posedge clk_sys_i);
      end
      si_i <= ~si_i;
   endtask
endmodule // serial_peer_model

// file: verif/serial_shift_checker.sv
// pin-level assertions for the clocked serial shift port
`timescale 1ns/1ps
module serial_shift_checker
   import serial_shift_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // register bus
   input wire apb_req_s apb_req_i,
   input wire apb_rsp_s apb_rsp_o,
   // serial pins
   input wire logic sck_i,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic si_i,
   input wire logic so_o,
   input wire logic so_oe_o
);
   logic [7:0] wr_addr_q;
   logic [3:0] wr_age_q;
   logic [3:0] fall_age_q;
   logic idle_q;
   logic lands;
   logic sck_now;
   assign lands = apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready && apb_req_i.pwrite;
   assign sck_now = sck_oe_o ? sck_o : sck_i;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         wr_age_q <= 4'hF;
      end else if (lands) begin
         wr_age_q <= 4'h0;
      end else if (wr_age_q != 4'hF) begin
         wr_age_q <= wr_age_q + 4'h1;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (lands) begin
         wr_addr_q <= apb_req_i.paddr;
         if (apb_req_i.paddr == ADDR_PORT_MODE_C) begin
            idle_q <= apb_req_i.pwdata[PORTC_IDLE_BIT];
         end
      end
   end
   // external edges reach the core late through the synchroniser
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || $fell(sck_now)) begin
         fall_age_q <= 4'h0;
      end else if (fall_age_q != 4'hF) begin
         fall_age_q <= fall_age_q + 4'h1;
      end
   end
   ready_pulse_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
      else $error("pready held too long");
   setup_ready_a: assert property (apb_req_i.psel && !apb_req_i.penable |=> apb_rsp_o.pready)
      else $error("no pready after setup");
   err_ready_a: assert property (apb_rsp_o.pslverr |-> apb_rsp_o.pready && apb_rsp_o.prdata == 32'h0)
      else $error("bad error response");
   so_oe_src_a: assert property ($changed(so_oe_o) |->
      wr_addr_q == ADDR_PORT_MODE_A && wr_age_q < 4'h3)
      else $error("so_oe_o moved without a mode write");
   sck_oe_src_a: assert property ($changed(sck_oe_o) |->
      wr_addr_q == ADDR_SERIAL_MODE && wr_age_q < 4'h3)
      else $error("sck_oe_o moved without a clock write");
   idle_level_a: assert property (lands && apb_req_i.paddr == ADDR_PORT_MODE_C && so_oe_o
      |-> ##[1:2] so_o == idle_q)
      else $error("so_o missed the idle level");
   so_cause_a: assert property ($changed(so_o) |-> fall_age_q < 4'h7 || $fell(sck_now)
      || wr_age_q < 4'h3)
      else $error("so_o changed off a falling edge");
   sck_drive_a: assert property ($fell(sck_o) |-> sck_oe_o)
      else $error("clock toggled while not driven");
   err_c: cover property (apb_rsp_o.pslverr);
   sck_c: cover property ($fell(sck_o) && sck_oe_o);
   so_c: cover property ($changed(so_o));
endmodule // serial_shift_checker

bind clocked_serial_shift_port serial_shift_checker chk_i (.clk_sys_i(clk_sys_i),
   .reset_i(reset_i), .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .sck_i(sck_i),
   .sck_o(sck_o), .sck_oe_o(sck_oe_o), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o));

// file: verif/tb_top.sv
// self-checking bench for the clocked serial shift port
`timescale 1ns/1ps
module tb_top
   import serial_shift_pkg::*;
();
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   apb_req_s apb_req = '0;
   apb_rsp_s apb_rsp;
   logic sck_i, sck_o, sck_oe_o, si_i, so_o, so_oe_o;
   logic [32:0] exp_q[$];
   int num_errors = 0;
   int compares = 0;
   logic [7:0] b, c, d;
   int n;
   always #20 clk_sys_i = ~clk_sys_i;
   clocked_serial_shift_port dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .apb_req_i(apb_req), .apb_rsp_o(apb_rsp), .sck_i(sck_i), .sck_o(sck_o),
      .sck_oe_o(sck_oe_o), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o));
   serial_peer_model peer (.clk_sys_i(clk_sys_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
      .so_o(so_o), .sck_i(sck_i), .si_i(si_i));
   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
      input logic [32:0] e);
      int k;
      k = 0;
      if (!w) exp_q.push_back(e);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
      @(posedge clk_sys_i);
      apb_req.penable <= 1'b1;
      do @(posedge clk_sys_i); while (apb_rsp.pready !== 1'b1 && k++ < 20);
      if (apb_rsp.pready !== 1'b1) begin
         num_errors++;
         $display("CHECK FAILED t=%0t no pready on bus", $time);
      end
      apb_req <= '0;
      @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      bus(1'b1, a, wd, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      bus(1'b0, a, 32'h0, e);
   endtask
   task automatic done_t(input string s);
      $display("test %s ended, errors %0d", s, num_errors);
   endtask
   task automatic summarize();
      num_errors += exp_q.size();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // read data checked in arrival order against the driver's notes
   always @(posedge clk_sys_i) begin
      if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready === 1'b1) begin
         chk({apb_rsp.pslverr, apb_rsp.prdata}, exp_q.pop_front());
      end
   end
   initial begin
      #400000;
      num_errors++;
      summarize();
   end
   initial begin
      void'($urandom(43608));
      idle(5);
      reset_i <= 1'b0;
      idle(1);
      rd(ADDR_STATUS, 33'h0);
      rd(8'h18, 33'h1_0000_0000);
      done_t("reset");
      b = 8'($urandom);
      c = 8'($urandom);
      d = 8'($urandom);
      wr(ADDR_PORT_MODE_A, 32'h3);
      wr(ADDR_SERIAL_MODE, 32'hF);
      wr(ADDR_PORT_MODE_C, 32'h2);
      idle(1);
      chk({32'h0, so_o}, 33'h1);
      chk({32'h0, so_oe_o}, 33'h1);
      wr(ADDR_PORT_MODE_C, 32'h0);
      idle(1);
      chk({32'h0, so_o}, 33'h0);
      wr(ADDR_SHIFT, {24'h0, b});
      wr(ADDR_COMMAND, 32'h1);
      peer.tx_q = c;
      peer.clocks(8, 6);
      idle(8);
      rd(ADDR_SHIFT, {25'h0, c});
      chk({25'h0, peer.rx_q}, {25'h0, b});
      chk({32'h0, so_o}, {32'h0, b[7]});
      rd(ADDR_STATUS, 33'h5);
      peer.tx_q = d;
      peer.clocks(8, 6);
      idle(8);
      rd(ADDR_SHIFT, {25'h0, d});
      chk({25'h0, peer.rx_q}, {25'h0, c});
      done_t("external");
      wr(ADDR_STATUS, 32'h1);
      wr(ADDR_COMMAND, 32'h1);
      peer.clocks(3, 6);
      idle(6);
      rd(ADDR_STATUS, 33'h38);
      wr(ADDR_COMMAND, 32'h1);
      rd(ADDR_STATUS, 33'h5);
      peer.clocks(3, 6);
      idle(6);
      wr(ADDR_SERIAL_MODE, 32'hF);
      rd(ADDR_STATUS, 33'h1);
      peer.clocks(8, 6);
      idle(6);
      rd(ADDR_STATUS, 33'h1);
      done_t("abort");
      wr(ADDR_PORT_MODE_A, 32'h2);
      wr(ADDR_PORT_MODE_C, 32'h2);
      wr(ADDR_COMMAND, 32'h1);
      peer.tx_q = d;
      peer.clocks(8, 6);
      idle(8);
      rd(ADDR_SHIFT, {25'h0, d});
      chk({31'h0, so_oe_o, so_o}, 33'h1);
      rd(ADDR_STATUS, 33'h5);
      wr(ADDR_PORT_MODE_A, 32'h3);
      done_t("receive");
      wr(ADDR_STATUS, 32'h1);
      wr(ADDR_SERIAL_MODE, 32'hD);
      wr(ADDR_PORT_MODE_C, 32'h1);
      wr(ADDR_SHIFT, {24'h0, b});
      peer.tx_q = c;
      peer.nrise = 0;
      wr(ADDR_COMMAND, 32'h1);
      for (n = 0; n < 400 && peer.nrise < 8; n++) idle(1);
      idle(40);
      chk({1'b0, 32'(peer.nrise)}, 33'h8);
      chk({32'h0, sck_o}, 33'h1);
      chk({32'h0, sck_oe_o}, 33'h1);
      chk({25'h0, peer.rx_q}, {25'h0, b});
      rd(ADDR_SHIFT, {25'h0, c});
      rd(ADDR_STATUS, 33'h1);
      done_t("internal");
      wr(ADDR_STATUS, 32'h1);
      wr(ADDR_PORT_MODE_A, 32'h0);
      wr(ADDR_SERIAL_MODE, 32'hD);
      peer.nrise = 0;
      wr(ADDR_COMMAND, 32'h1);
      idle(200);
      rd(ADDR_STATUS, 33'hC);
      rd(ADDR_SHIFT, {25'h0, c});
      chk({32'h0, peer.nrise > 8}, 33'h1);
      wr(ADDR_SERIAL_MODE, 32'hD);
      rd(ADDR_STATUS, 33'h0);
      done_t("continuous");
      summarize();
   end
endmodule // tb_top
